// ===== verilog/opmode_params.svh
// opmode_params.svh: register offsets, bit positions, reset values
// assumes inclusion by the operating-mode sequencer package and module
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH

// ---------------------------------------------
// register map
// ---------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_OPT       8'h04
`define OFS_STAT      8'h08

// ---------------------------------------------
// control register bits
// ---------------------------------------------
`define CTRL_FULL_DOWN 0
`define CTRL_PART_DOWN 1
`define CTRL_WAKE_FLAG 2
`define CTRL_ACK       3

// ---------------------------------------------
// option register bits
// ---------------------------------------------
`define OPT_HALT_OK    0
`define OPT_LVR_EN     1
`define OPT_DBG_EN     2
`define OPT_IRQ_WAKE   3
`define OPT_KB1_WAKE   4
`define OPT_KB2_WAKE   5
`define OPT_RTI_EN     6
`define OPT_RST        7'h00

// ---------------------------------------------
// pins, answers, timing
// ---------------------------------------------
`define PIN_W          8
`define PIN_RST        8'h00
`define INIT_CYC       2'h2
`define RESP_OKAY      2'h0
`define RESP_DECERR    2'h3
`define STAT_LATCH     4

`endif

// ===== verilog/opmode_pkg.sv
// opmode_pkg: types of the operating-mode sequencer
// assumes opmode_params.svh beside it
`include "opmode_params.svh"
package opmode_pkg;
   typedef enum logic [2:0] {
      M_INIT = 3'h0, M_RUN = 3'h1, M_BKGD = 3'h2, M_WAIT = 3'h3,
      M_SHALLOW = 3'h4, M_PARTIAL = 3'h5, M_DEEP = 3'h6
   } mode_t;
   typedef enum logic [2:0] {
      C_MEM = 3'h0, C_MEM_STAT = 3'h1, C_BDC_REG = 3'h2, C_BACKGROUND = 3'h3,
      C_CPU_REG = 3'h4, C_TRACE = 3'h5, C_GO = 3'h6
   } dbg_cmd_t;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_t;
   typedef struct packed {
      logic waitExec;
      logic stopExec;
      logic bgndExec;
      logic bdcBreak;
      logic dbgBreak;
      logic irqReq;
      logic rtiWake;
   } cpu_evt_t;
   typedef struct packed {
      logic modeSel;
      logic resetN;
      logic irqN;
      logic kb1N;
      logic kb2N;
   } pins_t;
   typedef struct packed {
      logic cpuClkEn;
      logic sysClkEn;
      logic periphClkEn;
      logic debugClkEn;
      logic oscEn;
      logic regulatorFull;
      logic ramOn;
      logic coreOn;
   } power_t;
   typedef struct packed {
      mode_t       mode;
      logic [1:0]  initCnt;
      pins_t       s1;
      pins_t       s2;
      logic        wakeRst;
      logic        wakeIrq;
      logic        fullDown;
      logic        partDown;
      logic        wakeFlag;
      logic [6:0]  opt;
      logic        latched;
      logic [7:0]  pinHeld;
      logic [7:0]  pinOut;
      power_t      pwr;
      logic        fetchVec;
      logic        sysRst;
      logic        illegalRst;
      logic        clrIMask;
      logic        takeIrq;
      logic        traceStep;
      logic        respV;
      logic        respErr;
      logic        awGot;
      logic        wGot;
      logic [7:0]  awAddr;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } st_t;
endpackage

// ===== verilog/operating_mode_sequencer.sv
// operating_mode_sequencer: run, background, wait and stop level control
// assumes one 100 MHz clock, AXI4-Lite master, pins async to clk
`timescale 1ns/1ns
`default_nettype none
`include "opmode_params.svh"
module operating_mode_sequencer (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // register bus
   input  wire opmode_pkg::axi_req_t  axiReq,
   output logic                       awready,
   output logic                       wready,
   output logic                       bvalid,
   output logic [1:0]                 bresp,
   output logic                       arready,
   output logic                       rvalid,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   // cpu events and pins
   input  wire opmode_pkg::cpu_evt_t  cpuEvt,
   input  wire opmode_pkg::pins_t     pinsIn,
   input  wire logic [7:0]            portDrive,
   output logic [7:0]                 pinOut,
   // debug command port
   input  wire logic                  dbgCmdValid,
   input  wire opmode_pkg::dbg_cmd_t  dbgCmd,
   output logic                       dbgCmdReady,
   output logic                       dbgRespValid,
   output logic                       dbgRespErr,
   // power and sequencing
   output opmode_pkg::power_t         power,
   output opmode_pkg::mode_t          modeOut,
   output logic                       fetchVector,
   output logic                       sysReset,
   output logic                       illegalOpReset,
   output logic                       clearIMask,
   output logic                       takeInterrupt,
   output logic                       traceStep
);
   import opmode_pkg::*;

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   st_t  s;
   st_t  n;
   logic halted;
   logic cmdTake;
   logic cmdOk;
   logic pinWake;
   logic dbgWake;
   logic runDbg;

   localparam st_t ST_RST = '{mode: M_INIT, opt: `OPT_RST, pinHeld: `PIN_RST,
      pinOut: `PIN_RST, default: '0};

   assign halted      = (s.mode == M_WAIT) || (s.mode == M_SHALLOW)
                     || (s.mode == M_PARTIAL) || (s.mode == M_DEEP);
   assign dbgCmdReady = (s.mode != M_INIT);
   assign cmdTake     = dbgCmdValid && dbgCmdReady;
   assign runDbg      = cpuEvt.bgndExec || cpuEvt.bdcBreak || cpuEvt.dbgBreak
                     || (cmdTake && dbgCmd == C_BACKGROUND);
   // active-low pin wakeups: reset always, irq and kb1 only when their option bits are set
   assign pinWake     = !s.s2.resetN || (s.opt[`OPT_IRQ_WAKE] && !s.s2.irqN)
                     || (s.opt[`OPT_KB1_WAKE] && !s.s2.kb1N);
   assign dbgWake     = cmdTake && dbgCmd == C_BACKGROUND
                     && (s.mode == M_WAIT || (s.mode == M_SHALLOW && s.opt[`OPT_DBG_EN]));

   // ---------------------------------------------
   // command acceptance per mode
   // ---------------------------------------------
   always_comb begin
      cmdOk = 1'b0;
      unique case (s.mode)
         M_RUN: cmdOk = (dbgCmd == C_MEM) || (dbgCmd == C_MEM_STAT)
                     || (dbgCmd == C_BDC_REG) || (dbgCmd == C_BACKGROUND);
         M_BKGD: cmdOk = (dbgCmd != 3'h7);
         M_WAIT, M_SHALLOW, M_PARTIAL, M_DEEP: cmdOk = dbgWake;
         M_INIT: cmdOk = 1'b0;
         default: cmdOk = 1'b0;
      endcase
   end

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      n            = s;
      n.s1         = pinsIn;
      n.s2         = s.s1;
      n.fetchVec   = 1'b0;
      n.sysRst     = 1'b0;
      n.illegalRst = 1'b0;
      n.clrIMask   = 1'b0;
      n.takeIrq    = 1'b0;
      n.traceStep  = 1'b0;
      n.respV      = cmdTake;
      n.respErr    = cmdTake && (!cmdOk || (halted && dbgCmd == C_MEM_STAT));
      // bus: address and data in either order
      if (axiReq.awvalid && !s.awGot && !s.bvalid) begin
         n.awGot  = 1'b1;
         n.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !s.wGot && !s.bvalid) begin
         n.wGot  = 1'b1;
         n.wData = axiReq.wdata;
         n.wStrb = axiReq.wstrb;
      end
      if (s.awGot && s.wGot) begin
         n.awGot  = 1'b0;
         n.wGot   = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `RESP_OKAY;
         if (s.awAddr == `OFS_CTRL) begin
            if (s.wStrb[0]) begin
               n.fullDown = s.wData[`CTRL_FULL_DOWN];
               n.partDown = s.wData[`CTRL_PART_DOWN];
               if (s.wData[`CTRL_ACK]) begin
                  n.latched  = 1'b0;
                  n.wakeFlag = 1'b0;
               end
            end
         end else if (s.awAddr == `OFS_OPT) begin
            if (s.wStrb[0]) begin
               n.opt = s.wData[6:0];
            end
         end else if (s.awAddr != `OFS_STAT) begin
            n.bresp = `RESP_DECERR;
         end
      end
      if (s.bvalid && axiReq.bready) begin
         n.bvalid = 1'b0;
      end
      if (axiReq.arvalid && !s.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = `RESP_OKAY;
         n.rdata  = 32'h0000_0000;
         if (axiReq.araddr == `OFS_CTRL) begin
            n.rdata[`CTRL_FULL_DOWN] = s.fullDown;
            n.rdata[`CTRL_PART_DOWN] = s.partDown;
            n.rdata[`CTRL_WAKE_FLAG] = s.wakeFlag;
         end else if (axiReq.araddr == `OFS_OPT) begin
            n.rdata[6:0] = s.opt;
         end else if (axiReq.araddr == `OFS_STAT) begin
            n.rdata[2:0]         = s.mode;
            n.rdata[`STAT_LATCH] = s.latched;
         end else begin
            n.rresp = `RESP_DECERR;
         end
      end else if (s.rvalid && axiReq.rready) begin
         n.rvalid = 1'b0;
      end
      // stop-level pin and rti wakes registered first, acted on next cycle; wait and debug wakes act at once
      n.wakeRst = 1'b0;
      n.wakeIrq = 1'b0;
      unique case (s.mode)
         M_INIT: begin
            n.initCnt = s.initCnt + 2'h1;
            if (s.initCnt == `INIT_CYC) begin
               n.initCnt = 2'h0;
               if (s.s2.modeSel) begin
                  n.mode     = M_RUN;
                  n.fetchVec = 1'b1;
               end else begin
                  n.mode = M_BKGD;
               end
            end
         end
         M_RUN: begin
            if (runDbg) begin
               n.mode = M_BKGD;
            end else if (cpuEvt.waitExec) begin
               n.mode     = M_WAIT;
               n.clrIMask = 1'b1;
            end else if (cpuEvt.stopExec) begin
               if (!s.opt[`OPT_HALT_OK]) begin
                  n.illegalRst = 1'b1;
                  n.sysRst     = 1'b1;
                  n.mode       = M_INIT;
                  n.fullDown   = 1'b0;
                  n.partDown   = 1'b0;
                  n.opt        = `OPT_RST;
               end else if (!s.fullDown || s.opt[`OPT_LVR_EN]
                            || s.opt[`OPT_DBG_EN]) begin
                  n.mode = M_SHALLOW;
               end else if (s.partDown) begin
                  n.mode    = M_PARTIAL;
                  n.latched = 1'b1;
                  n.pinHeld = s.pinOut;
               end else begin
                  n.mode = M_DEEP;
               end
            end
         end
         M_BKGD: begin
            if (cmdTake && dbgCmd == C_GO) begin
               n.mode = M_RUN;
            end
            n.traceStep = cmdTake && dbgCmd == C_TRACE;
         end
         M_WAIT: begin
            if (dbgWake) begin
               n.mode = M_BKGD;
            end else if (cpuEvt.irqReq) begin
               n.mode    = M_RUN;
               n.takeIrq = 1'b1;
            end
         end
         M_SHALLOW: begin
            n.wakeRst = !s.s2.resetN;
            n.wakeIrq = (s.opt[`OPT_IRQ_WAKE] && !s.s2.irqN)
                     || (s.opt[`OPT_KB1_WAKE] && !s.s2.kb1N)
                     || (s.opt[`OPT_KB2_WAKE] && !s.s2.kb2N)
                     || (s.opt[`OPT_RTI_EN] && cpuEvt.rtiWake);
            if (dbgWake) begin
               n.mode = M_BKGD;
            end else if (s.wakeRst) begin
               n.mode     = M_INIT;
               n.sysRst   = 1'b1;
               n.fullDown = 1'b0;
               n.partDown = 1'b0;
               n.opt      = `OPT_RST;
            end else if (s.wakeIrq) begin
               n.mode    = M_RUN;
               n.takeIrq = 1'b1;
            end
         end
         M_PARTIAL: begin
            n.wakeRst = pinWake || (s.opt[`OPT_RTI_EN] && cpuEvt.rtiWake);
            if (s.wakeRst) begin
               n.mode     = M_INIT;
               n.sysRst   = 1'b1;
               n.fullDown = 1'b0;
               n.partDown = 1'b0;
               n.opt      = `OPT_RST;
               n.wakeFlag = 1'b1;
            end
         end
         M_DEEP: begin
            n.wakeRst = pinWake;
            if (s.wakeRst) begin
               n.mode     = M_INIT;
               n.sysRst   = 1'b1;
               n.fullDown = 1'b0;
               n.partDown = 1'b0;
               n.opt      = `OPT_RST;
               n.wakeFlag = 1'b0;
            end
         end
         default: n.mode = M_INIT;
      endcase
      // pins: latched, forced to reset, or live port logic
      if (n.latched) begin
         n.pinOut = s.latched ? s.pinHeld : n.pinHeld;
      end else if (n.mode == M_DEEP) begin
         n.pinOut = `PIN_RST;
      end else begin
         n.pinOut = portDrive;
      end
      // clock gates and power follow the registered mode
      n.pwr = '0;
      unique case (n.mode)
         M_RUN, M_INIT: n.pwr = '{cpuClkEn: 1'b1, sysClkEn: 1'b1, periphClkEn: 1'b1,
            debugClkEn: 1'b1, oscEn: 1'b1, regulatorFull: 1'b1, ramOn: 1'b1, coreOn: 1'b1};
         M_BKGD: n.pwr = '{cpuClkEn: 1'b0, sysClkEn: 1'b1, periphClkEn: 1'b1,
            debugClkEn: 1'b1, oscEn: 1'b1, regulatorFull: 1'b1, ramOn: 1'b1,
            coreOn: 1'b1};
         M_WAIT: n.pwr = '{cpuClkEn: 1'b0, sysClkEn: 1'b1, periphClkEn: 1'b1,
            debugClkEn: 1'b1, oscEn: 1'b1, regulatorFull: 1'b1, ramOn: 1'b1,
            coreOn: 1'b1};
         M_SHALLOW: begin
            n.pwr.debugClkEn    = n.opt[`OPT_DBG_EN];
            n.pwr.regulatorFull = n.opt[`OPT_DBG_EN] || n.opt[`OPT_LVR_EN];
            n.pwr.ramOn         = 1'b1;
            n.pwr.coreOn        = 1'b1;
         end
         M_PARTIAL: n.pwr.ramOn = 1'b1;
         M_DEEP: n.pwr = '0;
         default: n.pwr = '0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= ST_RST;
      end else begin
         s <= n;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign awready        = !s.awGot && !s.bvalid;
   assign wready         = !s.wGot && !s.bvalid;
   assign bvalid         = s.bvalid;
   assign bresp          = s.bresp;
   assign arready        = !s.rvalid;
   assign rvalid         = s.rvalid;
   assign rdata          = s.rdata;
   assign rresp          = s.rresp;
   assign pinOut         = s.pinOut;
   assign dbgRespValid   = s.respV;
   assign dbgRespErr     = s.respErr;
   assign power          = s.pwr;
   assign modeOut        = s.mode;
   assign fetchVector    = s.fetchVec;
   assign sysReset       = s.sysRst;
   assign illegalOpReset = s.illegalRst;
   assign clearIMask     = s.clrIMask;
   assign takeInterrupt  = s.takeIrq;
   assign traceStep      = s.traceStep;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_init_run_vec: assert property (s.mode == M_INIT && n.mode == M_RUN
      |=> fetchVector && s.mode == M_RUN) else $error("run entry without vector");
   a_bkgd_entry: assert property (s.mode == M_RUN && cpuEvt.bgndExec
      |=> s.mode == M_BKGD) else $error("background entry missed");
   a_bkgd_cpu_off: assert property (s.mode == M_BKGD
      |-> !power.cpuClkEn && power.debugClkEn) else $error("cpu clocked in background");
   a_run_cpu_reg: assert property (s.mode == M_RUN && dbgCmdValid && dbgCmd == C_CPU_REG
      |=> dbgRespValid && dbgRespErr) else $error("cpu access taken in run");
   a_wait_clocks: assert property (s.mode == M_WAIT
      |-> !power.cpuClkEn && power.sysClkEn) else $error("wait clocking wrong");
   a_wait_irq: assert property (s.mode == M_WAIT && cpuEvt.irqReq && !dbgCmdValid
      |=> takeInterrupt && s.mode == M_RUN) else $error("wait interrupt missed");
   a_halt_status: assert property (halted && dbgCmdValid && dbgCmd == C_MEM_STAT
      |=> dbgRespValid && dbgRespErr) else $error("status command not refused");
   a_stop_illegal: assert property (s.mode == M_RUN && cpuEvt.stopExec && !runDbg
      && !cpuEvt.waitExec && !s.opt[`OPT_HALT_OK]
      |=> illegalOpReset && s.mode == M_INIT) else $error("illegal stop not reset");
   a_stop_clocks: assert property (s.mode inside {M_SHALLOW, M_PARTIAL, M_DEEP}
      |-> !power.sysClkEn && !power.cpuClkEn && !power.periphClkEn)
      else $error("clock running in stop");
   a_lvr_shallow: assert property (s.mode == M_RUN && cpuEvt.stopExec && !runDbg
      && !cpuEvt.waitExec && s.opt[`OPT_HALT_OK] && s.opt[`OPT_LVR_EN]
      |=> s.mode == M_SHALLOW) else $error("deep level with lvr");
   a_latch_hold: assert property (s.mode == M_PARTIAL
      |-> s.latched && pinOut == s.pinHeld) else $error("pins not held");
   a_flag_wake: assert property (s.mode == M_PARTIAL && s.wakeRst
      |=> s.wakeFlag && sysReset ##1 s.wakeFlag) else $error("wake flag missing");
   a_wake_delay: assert property (s.mode inside {M_PARTIAL, M_DEEP} && !s.wakeRst
      |=> $stable(s.mode)) else $error("stop left unsampled");

   c_partial_wake: cover property (s.mode == M_PARTIAL ##[1:50] s.mode == M_INIT);
   c_wait_bkgd: cover property (s.mode == M_WAIT ##1 s.mode == M_BKGD);
   c_shallow_irq: cover property (s.mode == M_SHALLOW ##[1:50] takeInterrupt);
   c_ack_release: cover property (s.latched ##1 !s.latched);
endmodule
`default_nettype wire

// ===== verif/wake_pin_model.sv
// wake_pin_model: reset, mode-select and wakeup pins at the far side
// assumes press requests come from the bench right after a clock edge
`timescale 1ns/1ns
`default_nettype none
module wake_pin_model (
   // requests
   input  wire logic              runSel,
   input  wire logic [3:0]        press,
   // pins
   output var opmode_pkg::pins_t  pins
);
   import opmode_pkg::*;
   // -----------------------------
   // pins rest high, pull low to wake
   // -----------------------------
   assign pins = '{runSel, ~press[3], ~press[2], ~press[1], ~press[0]};
endmodule
`default_nettype wire

// ===== verif/operating_mode_sequencer_test.sv
// operating_mode_sequencer_test: self-checking bench of the sequencer
// assumes the package, the design and the wake pin model compile first
`timescale 1ns/1ns
`default_nettype none
`include "opmode_params.svh"
module operating_mode_sequencer_test;
   import opmode_pkg::*;
   logic        clk, arst_n, runSel, dbgCmdValid, awready, wready, bvalid;
   logic        arready, rvalid, dbgCmdReady, dbgRespValid, dbgRespErr;
   logic        fetchVector, sysReset, illegalOpReset, clearIMask;
   logic        takeInterrupt, traceStep;
   logic [1:0]  bresp, rresp, resp;
   logic [3:0]  press;
   logic [7:0]  portDrive, pinOut, held;
   logic [31:0] rdata, dat;
   axi_req_t    req;
   cpu_evt_t    cpuEvt;
   pins_t       pinsIn;
   dbg_cmd_t    dbgCmd;
   power_t      power;
   mode_t       modeOut;
   int          badCount, nChecks;
   int unsigned seed = 69;
   logic        dbgOn = 1'b0;

   operating_mode_sequencer u_dut (.clk, .arst_n, .axiReq(req), .awready, .wready,
      .bvalid, .bresp, .arready, .rvalid, .rdata, .rresp, .cpuEvt, .pinsIn,
      .portDrive, .pinOut, .dbgCmdValid, .dbgCmd, .dbgCmdReady, .dbgRespValid,
      .dbgRespErr, .power, .modeOut, .fetchVector, .sysReset, .illegalOpReset,
      .clearIMask, .takeInterrupt, .traceStep);
   wake_pin_model u_pins (.runSel, .press, .pins(pinsIn));

   // -----------------------------
   // model and helpers
   // -----------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic cmdErr(int m, int c);
      if (m == 2) return c > 6;
      if (m == 1) return c > 3;
      return !(c == 3 && (m == 3 || (m == 4 && dbgOn)));
   endfunction
   task automatic ck(string n, logic [31:0] e, logic [31:0] g);
      nChecks++;
      if (g !== e) begin
         badCount++;
         $display("mismatch %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic wm(mode_t m);
      int t;
      t = 0;
      do @(negedge clk); while (modeOut !== m && ++t < 40);
      ck("mode", m, modeOut);
   endtask
   task automatic ev(logic [6:0] m);
      @(posedge clk);
      cpuEvt <= m;
      @(posedge clk);
      cpuEvt <= '0;
      @(negedge clk);
   endtask
   task automatic pr(logic [3:0] p);
      @(posedge clk);
      press <= p;
   endtask
   task automatic dc(int c);
      int m;
      m = modeOut;
      ck("ready", 1, dbgCmdReady);
      @(posedge clk);
      dbgCmdValid <= 1'h1;
      dbgCmd <= dbg_cmd_t'(c);
      @(posedge clk);
      dbgCmdValid <= 1'h0;
      @(negedge clk);
      ck("resp", 1, dbgRespValid);
      ck("err", cmdErr(m, c), dbgRespErr);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
      logic ra, rw, rb;
      @(posedge clk);
      req <= '{1'h1, a, 1'h1, d, 4'hF, 1'h1, 1'h0, 8'h00, 1'h0};
      do begin
         @(negedge clk);
         ra = awready;
         rw = wready;
         rb = bvalid;
         r = bresp;
         @(posedge clk);
         req.awvalid <= req.awvalid & !ra;
         req.wvalid <= req.wvalid & !rw;
      end while (!rb);
      req.bready <= 1'h0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ra, rv;
      @(posedge clk);
      req <= '{1'h0, 8'h00, 1'h0, 32'h0, 4'h0, 1'h0, 1'h1, a, 1'h1};
      do begin
         @(negedge clk);
         ra = arready;
         rv = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         req.arvalid <= req.arvalid & !ra;
      end while (!rv);
      req.rready <= 1'h0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // -----------------------------
   // clock, watchdog, tests
   // -----------------------------
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      stop_test;
   end
   initial begin
      arst_n = 0;
      runSel = 1;
      press = 0;
      portDrive = 0;
      req = '0;
      cpuEvt = '0;
      dbgCmdValid = 0;
      dbgCmd = C_MEM;
      repeat (16) @(posedge clk);
      arst_n <= 1'h1;
      wm(M_RUN);
      ck("vector", 1, fetchVector);
      rd(`OFS_OPT, dat, resp);
      ck("opt", 0, dat);
      rd(8'h0C, dat, resp);
      ck("rresp", 3, resp);
      for (int c = 0; c < 7; c++) dc(c);
      wm(M_RUN);
      for (int b = 2; b < 5; b++) begin
         ev(7'h01 << b);
         wm(M_BKGD);
         dc(5);
         ck("trace", 1, traceStep);
         dc(6);
      end
      $display("test debug done");
      ev(7'h40);
      ck("imask", 1, clearIMask);
      ck("clk", 2'h1, {power.cpuClkEn, power.sysClkEn});
      dc(1);
      ev(7'h02);
      ck("irq", 1, takeInterrupt);
      wm(M_RUN);
      ev(7'h40);
      dc(3);
      wm(M_BKGD);
      dc(6);
      ev(7'h20);
      ck("illegal", 1, illegalOpReset);
      wm(M_RUN);
      $display("test wait done");
      wr(`OFS_OPT, 1, resp);
      wr(`OFS_CTRL, 3, resp);
      ck("bresp", 0, resp);
      held = rnd();
      portDrive <= held;
      ev(7'h20);
      wm(M_PARTIAL);
      ck("clocks", 0, {power.cpuClkEn, power.sysClkEn, power.periphClkEn});
      pr(4'h1);
      portDrive <= rnd();
      repeat (8) @(negedge clk);
      ck("kb2", M_PARTIAL, modeOut);
      ck("held", held, pinOut);
      ck("ram", 1, power.ramOn);
      rd(`OFS_STAT, dat, resp);
      ck("stat", 32'(M_PARTIAL) | (32'h1 << `STAT_LATCH), dat);
      pr(4'h8);
      wm(M_INIT);
      ck("sysrst", 1, sysReset);
      pr(4'h0);
      wm(M_RUN);
      ck("vector", 1, fetchVector);
      ck("held", held, pinOut);
      rd(`OFS_CTRL, dat, resp);
      ck("ctrl", 32'h4, dat);
      portDrive <= rnd();
      wr(`OFS_CTRL, 8, resp);
      repeat (3) @(negedge clk);
      ck("pins", portDrive, pinOut);
      rd(`OFS_CTRL, dat, resp);
      ck("ctrl", 0, dat);
      $display("test partial done");
      wr(`OFS_OPT, 32'hB, resp);
      wr(`OFS_CTRL, 3, resp);
      ev(7'h20);
      wm(M_SHALLOW);
      ck("standby", 2'h3, {power.ramOn, power.coreOn});
      pr(4'h4);
      wm(M_RUN);
      ck("irq", 1, takeInterrupt);
      pr(4'h0);
      wr(`OFS_OPT, 5, resp);
      ev(7'h20);
      wm(M_SHALLOW);
      ck("dbgclk", 2'h3, {power.debugClkEn, power.regulatorFull});
      dbgOn = 1'b1;
      dc(3);
      wm(M_BKGD);
      dc(6);
      wr(`OFS_OPT, 32'h11, resp);
      wr(`OFS_CTRL, 1, resp);
      ev(7'h20);
      wm(M_DEEP);
      ck("pins", 0, pinOut);
      ck("power", 0, power);
      pr(4'h2);
      wm(M_INIT);
      ck("sysrst", 1, sysReset);
      pr(4'h0);
      wm(M_RUN);
      ck("vector", 1, fetchVector);
      wr(8'h0C, 1, resp);
      ck("bresp", 3, resp);
      $display("test stop done");
      stop_test;
   end
endmodule
`default_nettype wire
